// *** rtl/nvsram_defs.svh ***
// constants for the nonvolatile sram sequence host
// assumes a 50 mhz system clock and an asynchronous sram style bus
`ifndef NVSRAM_DEFS_SVH
`define NVSRAM_DEFS_SVH

// ==========================================================
// bus shape
`define MEM_ADDR_W     20
`define MEM_DATA_W     16

// ==========================================================
// command sequence addresses
`define SEQ_ADDR_0     16'h4e38
`define SEQ_ADDR_1     16'hb1c7
`define SEQ_ADDR_2     16'h83e0
`define SEQ_ADDR_3     16'h7c1f
`define SEQ_ADDR_4     16'h703f
`define SEQ_ADDR_STORE 16'h8fc0
`define SEQ_ADDR_RECALL 16'h4c63
`define SEQ_ADDR_AS_OFF 16'h8b45
`define SEQ_ADDR_AS_ON 16'h4b46
`define SEQ_LAST_IDX   3'h5
`define SEQ_IDX_STEP   3'h1

// ==========================================================
// timing, in ns unless named otherwise
`define CLK_PERIOD_NS  20
`define T_ACCESS_NS    45
`define T_OP_NS        10000000
`define T_RECOVERY_NS  1000
`define CNT_W          20

`endif

// *** rtl/nvsram_pkg.sv ***
// types shared by the sequence host and its bus cycle engine
// assumes nvsram_defs.svh is on the include path
`include "nvsram_defs.svh"

package nvsram_pkg;

  // ==========================================================
  // host commands
  typedef enum logic [2:0] {
    CMD_READ       = 3'h0,
    CMD_WRITE      = 3'h1,
    CMD_STORE      = 3'h2,
    CMD_RECALL     = 3'h3,
    CMD_AS_DISABLE = 3'h4,
    CMD_AS_ENABLE  = 3'h5
  } cmd_t;

  // ==========================================================
  // pins toward the memory, all strobes active low
  typedef struct packed {
    logic                   ceN;
    logic                   oeN;
    logic                   weN;
    logic [`MEM_ADDR_W-1:0] addr;
    logic [`MEM_DATA_W-1:0] dqOut;
    logic                   dqOe;
  } memPins_t;

  // ==========================================================
  // state machines
  typedef enum logic [3:0] {
    B_IDLE   = 4'h1,
    B_SETUP  = 4'h2,
    B_STROBE = 4'h4,
    B_END    = 4'h8
  } busState_t;

  typedef enum logic [4:0] {
    H_IDLE    = 5'h01,
    H_XFER    = 5'h02,
    H_SEQ     = 5'h04,
    H_OPWAIT  = 5'h08,
    H_RECOVER = 5'h10
  } hostState_t;

endpackage

// *** rtl/bus_cycle.sv ***
// one asynchronous sram read or write cycle, driven from flops
// assumes start is only raised while idle and data input is synchronous
`timescale 1ns/1ns
`include "nvsram_defs.svh"

module bus_cycle #(
  parameter int unsigned AccessNs = `T_ACCESS_NS
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire logic                    start,
  input  wire logic                    isWrite,
  input  wire logic [`MEM_ADDR_W-1:0]  addr,
  input  wire logic [`MEM_DATA_W-1:0]  wdata,
  input  wire logic [`MEM_DATA_W-1:0]  memDqIn,
  output nvsram_pkg::memPins_t         pins,
  output logic [`MEM_DATA_W-1:0]       rdata,
  output logic                         done
);

  // least time, so round up
  localparam logic [7:0] AccessCyc =
    8'((AccessNs + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);

  nvsram_pkg::busState_t state_q, state_d;
  nvsram_pkg::memPins_t  pins_q, pins_d;
  logic [7:0]            cnt_q, cnt_d;
  logic [`MEM_DATA_W-1:0] rdata_q, rdata_d;
  logic                  done_q, done_d;
  logic                  wr_q, wr_d;

  // ==========================================================
  // next state
  always_comb begin
    state_d = state_q;
    pins_d  = pins_q;
    cnt_d   = cnt_q;
    rdata_d = rdata_q;
    done_d  = 1'b0;
    wr_d    = wr_q;
    case (state_q)
      nvsram_pkg::B_IDLE: begin
        if (start) begin
          // address settles before any strobe falls
          pins_d.addr  = addr;
          pins_d.dqOut = wdata;
          pins_d.dqOe  = isWrite;
          wr_d         = isWrite;
          state_d      = nvsram_pkg::B_SETUP;
        end
      end
      nvsram_pkg::B_SETUP: begin
        pins_d.ceN = 1'b0;
        pins_d.oeN = wr_q;
        pins_d.weN = ~wr_q; // reads keep write enable high all cycle
        cnt_d      = 8'h01;
        state_d    = nvsram_pkg::B_STROBE;
      end
      nvsram_pkg::B_STROBE: begin
        if (cnt_q >= AccessCyc) begin
          rdata_d    = memDqIn;
          pins_d.ceN = 1'b1;
          pins_d.oeN = 1'b1;
          pins_d.weN = 1'b1;
          done_d     = 1'b1;
          state_d    = nvsram_pkg::B_END;
        end else begin
          cnt_d = cnt_q + 8'h01;
        end
      end
      nvsram_pkg::B_END: begin
        // data held one cycle past the write strobe rising
        pins_d.dqOe = 1'b0;
        state_d     = nvsram_pkg::B_IDLE;
      end
      default: begin
        state_d = nvsram_pkg::B_IDLE;
      end
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= nvsram_pkg::B_IDLE;
      pins_q  <= '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1, addr: '0, dqOut: '0, dqOe: 1'b0};
      cnt_q   <= 8'h00;
      rdata_q <= '0;
      done_q  <= 1'b0;
      wr_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      pins_q  <= pins_d;
      cnt_q   <= cnt_d;
      rdata_q <= rdata_d;
      done_q  <= done_d;
      wr_q    <= wr_d;
    end
  end

  assign pins  = pins_q;
  assign rdata = rdata_q;
  assign done  = done_q;

endmodule

// *** rtl/nvsram_seq_host.sv ***
// host controller for a nonvolatile sram: plain reads and writes, and
// six-read command sequences for store, recall and auto save on or off
// assumes the memory busy line is sampled synchronously, high when idle
//
// Overview of operation
// - store sequence: five leading reads, then 0x8fc0
// - recall sequence: five leading reads, then 0x4c63
// - auto save off: five leading reads, then 0x8b45
// - auto save on: five leading reads, then 0x4b46
// - nothing else may interrupt a sequence
// - write enable stays high for all six reads
// - follow auto save change with a store
`timescale 1ns/1ns
`include "nvsram_defs.svh"

module nvsram_seq_host #(
  parameter int unsigned AccessNs   = `T_ACCESS_NS,
  parameter int unsigned OpTimeNs   = `T_OP_NS,
  parameter int unsigned RecoveryNs = `T_RECOVERY_NS
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic                   reqValid,
  input  nvsram_pkg::cmd_t            reqCmd,
  input  wire logic [`MEM_ADDR_W-1:0] reqAddr,
  input  wire logic [`MEM_DATA_W-1:0] reqWdata,
  input  wire logic                   supplyOk,
  input  wire logic                   busyLineIn,
  input  wire logic [`MEM_DATA_W-1:0] memDqIn,
  output logic                        reqReady,
  output logic                        rspValid,
  output logic [`MEM_DATA_W-1:0]      rspData,
  output nvsram_pkg::memPins_t        memPins
);

  // least times, so round up; the operation wait can be shortened for simulation
  localparam logic [`CNT_W-1:0] OpCyc =
    `CNT_W'((OpTimeNs + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);
  localparam logic [`CNT_W-1:0] RecoveryCyc =
    `CNT_W'((RecoveryNs + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);
  localparam logic [`CNT_W-1:0] CntOne = `CNT_W'(1);

  nvsram_pkg::hostState_t state_q, state_d;
  nvsram_pkg::cmd_t       cmd_q, cmd_d;
  logic [2:0]             idx_q, idx_d;
  logic [`CNT_W-1:0]      cnt_q, cnt_d;
  logic                   ready_q, ready_d;
  logic                   rspValid_q, rspValid_d;
  logic [`MEM_DATA_W-1:0] rspData_q, rspData_d;
  logic                   start_q, start_d;
  logic                   write_q, write_d;
  logic [`MEM_ADDR_W-1:0] addr_q, addr_d;
  logic [`MEM_DATA_W-1:0] wdata_q, wdata_d;
  logic                   busDone;
  logic [`MEM_DATA_W-1:0] busRdata;

  // ==========================================================
  // sequence address table
  // upper bits stay zero; the device ignores all but bits 14 to 2 anyway
  function automatic logic [`MEM_ADDR_W-1:0] seqAddr(
    input logic [2:0]       idx,
    input nvsram_pkg::cmd_t cmd
  );
    logic [15:0] a;
    a = `SEQ_ADDR_0;
    case (idx)
      3'h0: a = `SEQ_ADDR_0;
      3'h1: a = `SEQ_ADDR_1;
      3'h2: a = `SEQ_ADDR_2;
      3'h3: a = `SEQ_ADDR_3;
      3'h4: a = `SEQ_ADDR_4;
      default: begin
        case (cmd)
          nvsram_pkg::CMD_STORE:      a = `SEQ_ADDR_STORE;
          nvsram_pkg::CMD_RECALL:     a = `SEQ_ADDR_RECALL;
          nvsram_pkg::CMD_AS_DISABLE: a = `SEQ_ADDR_AS_OFF;
          default:                    a = `SEQ_ADDR_AS_ON;
        endcase
      end
    endcase
    return `MEM_ADDR_W'(a);
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    state_d    = state_q;
    cmd_d      = cmd_q;
    idx_d      = idx_q;
    cnt_d      = cnt_q;
    ready_d    = 1'b0;
    rspValid_d = 1'b0;
    rspData_d  = rspData_q;
    start_d    = 1'b0;
    write_d    = write_q;
    addr_d     = addr_q;
    wdata_d    = wdata_q;
    case (state_q)
      nvsram_pkg::H_IDLE: begin
        // refuse work at low supply or while the device is busy
        ready_d = supplyOk & busyLineIn;
        if (reqValid && ready_q) begin
          ready_d = 1'b0;
          cmd_d   = reqCmd;
          start_d = 1'b1;
          if (reqCmd == nvsram_pkg::CMD_READ || reqCmd == nvsram_pkg::CMD_WRITE) begin
            write_d = (reqCmd == nvsram_pkg::CMD_WRITE);
            addr_d  = reqAddr;
            wdata_d = reqWdata;
            state_d = nvsram_pkg::H_XFER;
          end else begin
            // every sequence opens at its first address
            idx_d   = 3'h0;
            write_d = 1'b0;
            addr_d  = seqAddr(3'h0, reqCmd);
            state_d = nvsram_pkg::H_SEQ;
          end
        end
      end
      nvsram_pkg::H_XFER: begin
        if (busDone) begin
          rspValid_d = 1'b1;
          rspData_d  = busRdata;
          state_d    = nvsram_pkg::H_IDLE;
        end
      end
      nvsram_pkg::H_SEQ: begin
        // no other access is let in until the sixth read ends
        if (busDone) begin
          if (idx_q == `SEQ_LAST_IDX) begin
            if (cmd_q == nvsram_pkg::CMD_STORE || cmd_q == nvsram_pkg::CMD_RECALL) begin
              // sixth read data is high impedance, so it is dropped
              cnt_d   = '0;
              state_d = nvsram_pkg::H_OPWAIT;
            end else begin
              // make the auto save setting survive power loss; a store runs
              // regardless of writes, and this is issued even though the
              // disable is known not to take
              cmd_d   = nvsram_pkg::CMD_STORE;
              idx_d   = 3'h0;
              addr_d  = seqAddr(3'h0, nvsram_pkg::CMD_STORE);
              start_d = 1'b1;
            end
          end else begin
            idx_d   = idx_q + `SEQ_IDX_STEP;
            addr_d  = seqAddr(idx_q + `SEQ_IDX_STEP, cmd_q);
            start_d = 1'b1;
          end
        end
      end
      nvsram_pkg::H_OPWAIT: begin
        // stay off the bus for the whole cycle time and until busy rises
        if (cnt_q < OpCyc) begin
          cnt_d = cnt_q + CntOne;
        end else if (busyLineIn) begin
          cnt_d   = '0;
          state_d = nvsram_pkg::H_RECOVER;
        end
      end
      nvsram_pkg::H_RECOVER: begin
        // writes right after busy releases would be swallowed
        if (cnt_q < RecoveryCyc) begin
          cnt_d = cnt_q + CntOne;
        end else begin
          rspValid_d = 1'b1;
          rspData_d  = '0;
          state_d    = nvsram_pkg::H_IDLE;
        end
      end
      default: begin
        state_d = nvsram_pkg::H_IDLE;
      end
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q    <= nvsram_pkg::H_IDLE;
      cmd_q      <= nvsram_pkg::CMD_READ;
      idx_q      <= 3'h0;
      cnt_q      <= '0;
      ready_q    <= 1'b0;
      rspValid_q <= 1'b0;
      rspData_q  <= '0;
      start_q    <= 1'b0;
      write_q    <= 1'b0;
      addr_q     <= '0;
      wdata_q    <= '0;
    end else begin
      state_q    <= state_d;
      cmd_q      <= cmd_d;
      idx_q      <= idx_d;
      cnt_q      <= cnt_d;
      ready_q    <= ready_d;
      rspValid_q <= rspValid_d;
      rspData_q  <= rspData_d;
      start_q    <= start_d;
      write_q    <= write_d;
      addr_q     <= addr_d;
      wdata_q    <= wdata_d;
    end
  end

  // ==========================================================
  // bus cycle engine
  bus_cycle #(
    .AccessNs (AccessNs)
  ) uCycle (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (start_q),
    .isWrite (write_q),
    .addr    (addr_q),
    .wdata   (wdata_q),
    .memDqIn (memDqIn),
    .pins    (memPins),
    .rdata   (busRdata),
    .done    (busDone)
  );

  assign reqReady = ready_q;
  assign rspValid = rspValid_q;
  assign rspData  = rspData_q;

endmodule

// *** tb/nvsram_seq_host_props.sv ***
// checker for the nonvolatile sram sequence host
// assumes only the host's top-level ports are visible
`timescale 1ns/1ns
`include "nvsram_defs.svh"

module nvsram_seq_host_props (
  input wire logic            clk_sys,
  input wire logic            rst,
  input wire logic            reqValid,
  input nvsram_pkg::cmd_t     reqCmd,
  input wire logic            supplyOk,
  input wire logic            busyLineIn,
  input wire logic            reqReady,
  input wire logic            rspValid,
  input nvsram_pkg::memPins_t memPins
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic take;
  logic seqOn_q;
  logic seqOn_d;
  // ==========================================================
  // sequence tracking
  assign take = reqValid && reqReady;
  always_comb begin
    seqOn_d = seqOn_q;
    if (rspValid) seqOn_d = 1'b0;
    if (take && reqCmd >= nvsram_pkg::CMD_STORE) seqOn_d = 1'b1;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) seqOn_q <= 1'b0;
    else seqOn_q <= seqOn_d;
  end
  // ==========================================================
  // properties
  property p_seq_we;
    seqOn_q |-> memPins.weN;
  endproperty
  a_seq_we: assert property (p_seq_we)
    else $error("write strobe low in sequence");
  property p_first_addr;
    take && reqCmd >= nvsram_pkg::CMD_STORE |-> ##[1:4] (!memPins.ceN && memPins.addr[15:0] == `SEQ_ADDR_0);
  endproperty
  a_first_addr: assert property (p_first_addr)
    else $error("sequence did not open at first address");
  property p_read_lat;
    take && reqCmd == nvsram_pkg::CMD_READ |-> ##[7:8] rspValid;
  endproperty
  a_read_lat: assert property (p_read_lat)
    else $error("read answer late");
  property p_read_no_drive;
    !memPins.oeN |-> !memPins.dqOe;
  endproperty
  a_read_no_drive: assert property (p_read_no_drive)
    else $error("host drives data during read");
  property p_quiet_busy;
    !busyLineIn |-> memPins.ceN;
  endproperty
  a_quiet_busy: assert property (p_quiet_busy)
    else $error("access while memory busy");
  property p_rsp_after_busy;
    !busyLineIn |=> !rspValid [*2];
  endproperty
  a_rsp_after_busy: assert property (p_rsp_after_busy)
    else $error("answer before recovery");
  property p_supply_refuse;
    !supplyOk |=> !reqReady;
  endproperty
  a_supply_refuse: assert property (p_supply_refuse)
    else $error("ready while supply low");
  property p_take_drop;
    take |=> !reqReady;
  endproperty
  a_take_drop: assert property (p_take_drop)
    else $error("second request open");
  property p_ready_back;
    rspValid && supplyOk && busyLineIn |=> !rspValid && reqReady;
  endproperty
  a_ready_back: assert property (p_ready_back)
    else $error("ready not restored");
endmodule

bind nvsram_seq_host nvsram_seq_host_props i_props (.clk_sys(clk_sys), .rst(rst),
  .reqValid(reqValid), .reqCmd(reqCmd), .supplyOk(supplyOk), .busyLineIn(busyLineIn),
  .reqReady(reqReady), .rspValid(rspValid), .memPins(memPins));

// *** tb/nvsram_dev_model.sv ***
// behavioural nonvolatile sram with the six-read command decoder
// assumes host strobes change only on clk_sys rising edges
`timescale 1ns/1ns
`include "nvsram_defs.svh"

module nvsram_dev_model #(
  parameter int BusyCyc = 20,
  parameter int RecCyc  = 2
) (
  input  wire logic            clk_sys,
  input  nvsram_pkg::memPins_t pins,
  input  wire logic            supplyOk,
  output logic [15:0]          memDqIn,
  output logic                 busyLineIn,
  output logic [7:0]           storeCnt,
  output logic                 autoOn
);
  logic [15:0] mem [16];
  logic [15:0] nv [16];
  logic [15:0] key [9];
  logic [15:0] lastDq;
  logic [15:0] curA;
  logic        curW;
  logic        act;
  logic        float;
  logic [2:0]  idx;
  int          busyCnt;
  int          recCnt = 0;
  function automatic logic m(input logic [15:0] a, input logic [15:0] k);
    return a[14:2] == k[14:2];
  endfunction
  initial begin
    key = '{`SEQ_ADDR_0, `SEQ_ADDR_1, `SEQ_ADDR_2, `SEQ_ADDR_3, `SEQ_ADDR_4,
      `SEQ_ADDR_STORE, `SEQ_ADDR_RECALL, `SEQ_ADDR_AS_OFF, `SEQ_ADDR_AS_ON};
    for (int i = 0; i < 16; i++) begin
      mem[i] = 16'h0000;
      nv[i] = 16'h0000;
    end
    autoOn = 1'b1;
    {idx, busyCnt, storeCnt, act, lastDq} = '0;
  end
  // ==========================================================
  // data lines: no pull, so a released bus shows a moving pattern
  assign busyLineIn = (busyCnt == 0);
  assign float = idx == 3'h5 && (m(pins.addr[15:0], key[5]) || m(pins.addr[15:0], key[6]));
  assign memDqIn = (!pins.ceN && !pins.oeN && pins.weN && busyLineIn && !float) ?
    mem[pins.addr[3:0]] : ~lastDq;
  always @(posedge clk_sys) begin
    lastDq <= memDqIn;
    if (busyCnt > 0) busyCnt <= busyCnt - 1;
    // writes right after busy releases are swallowed, so a hasty host loses data
    if (busyCnt == 1) recCnt <= RecCyc;
    else if (recCnt > 0) recCnt <= recCnt - 1;
    act <= !pins.ceN;
    if (!pins.ceN) begin
      curA <= pins.addr[15:0];
      curW <= !pins.weN;
      if (!pins.weN && busyLineIn && supplyOk && recCnt == 0) begin
        mem[pins.addr[3:0]] <= pins.dqOut;
      end
    end else if (act && busyLineIn) begin
      if (curW) idx <= 3'h0;
      else if (idx < 3'h5) idx <= m(curA, key[idx]) ? idx + 3'h1 : {2'b00, m(curA, key[0])};
      else begin
        idx <= 3'h0;
        if (m(curA, key[5]) && supplyOk) begin
          nv <= mem;
          storeCnt <= storeCnt + 8'h01;
          busyCnt <= BusyCyc;
        end
        if (m(curA, key[6])) begin
          mem <= nv;
          busyCnt <= BusyCyc;
        end
        if (m(curA, key[7])) autoOn <= autoOn;
        if (m(curA, key[8])) autoOn <= 1'b1;
      end
    end
  end
endmodule

// *** tb/test_nvsram_seq_host.sv ***
// self-checking bench for the nonvolatile sram sequence host
// assumes the device model and the bound checker are compiled with it
`timescale 1ns/1ns
`include "nvsram_defs.svh"

module test_nvsram_seq_host;
  typedef struct {
    nvsram_pkg::cmd_t c;
    logic [19:0]      a;
    logic [15:0]      d;
    logic [15:0]      e;
    logic [7:0]       s;
  } row_t;
  logic                 clk_sys = 1'b0;
  logic                 rst = 1'b1;
  logic                 reqValid = 1'b0;
  logic                 supplyOk = 1'b1;
  nvsram_pkg::cmd_t     reqCmd = nvsram_pkg::CMD_READ;
  logic [19:0]          reqAddr = 20'h00000;
  logic [15:0]          reqWdata = 16'h0000;
  logic                 busyLineIn;
  logic [15:0]          memDqIn;
  logic                 reqReady;
  logic                 rspValid;
  logic [15:0]          rspData;
  nvsram_pkg::memPins_t memPins;
  logic [7:0]           storeCnt;
  logic                 autoOn;
  int                   fails = 0;
  int                   compares = 0;
  row_t                 rows [10];

  nvsram_seq_host #(.AccessNs(45), .OpTimeNs(200), .RecoveryNs(40)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .reqValid(reqValid), .reqCmd(reqCmd),
    .reqAddr(reqAddr), .reqWdata(reqWdata), .supplyOk(supplyOk),
    .busyLineIn(busyLineIn), .memDqIn(memDqIn), .reqReady(reqReady),
    .rspValid(rspValid), .rspData(rspData), .memPins(memPins));
  nvsram_dev_model #(.BusyCyc(20), .RecCyc(2)) i_dev (.clk_sys(clk_sys), .pins(memPins),
    .supplyOk(supplyOk), .memDqIn(memDqIn), .busyLineIn(busyLineIn),
    .storeCnt(storeCnt), .autoOn(autoOn));

  always #10 clk_sys = ~clk_sys;

  // ==========================================================
  // compare and request tasks
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk16({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic summarize;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // request held until ready is seen, answer taken at its pulse
  task automatic req(input nvsram_pkg::cmd_t c, input logic [19:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reqValid <= 1'b1;
    reqCmd <= c;
    reqAddr <= a;
    reqWdata <= d;
    do @(negedge clk_sys); while (reqReady !== 1'b1);
    @(posedge clk_sys);
    reqValid <= 1'b0;
    do @(negedge clk_sys); while (rspValid !== 1'b1);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rows = '{'{nvsram_pkg::CMD_READ, 20'h00003, 16'h0000, 16'h0000, 8'h00},
      '{nvsram_pkg::CMD_WRITE, 20'h00005, 16'ha5a5, 16'h0000, 8'h00},
      '{nvsram_pkg::CMD_STORE, 20'h00000, 16'h0000, 16'h0000, 8'h01},
      '{nvsram_pkg::CMD_STORE, 20'h00000, 16'h0000, 16'h0000, 8'h02},
      '{nvsram_pkg::CMD_WRITE, 20'h00005, 16'h1234, 16'h0000, 8'h02},
      '{nvsram_pkg::CMD_READ, 20'h00005, 16'h0000, 16'h1234, 8'h02},
      '{nvsram_pkg::CMD_RECALL, 20'h00000, 16'h0000, 16'h0000, 8'h02},
      '{nvsram_pkg::CMD_READ, 20'h00005, 16'h0000, 16'ha5a5, 8'h02},
      '{nvsram_pkg::CMD_AS_DISABLE, 20'h00000, 16'h0000, 16'h0000, 8'h03},
      '{nvsram_pkg::CMD_AS_ENABLE, 20'h00000, 16'h0000, 16'h0000, 8'h04}};
    repeat (8) @(posedge clk_sys);
    chk1(reqReady, 1'b0);
    chk1(memPins.ceN, 1'b1);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      req(rows[i].c, rows[i].a, rows[i].d);
      if (rows[i].c == nvsram_pkg::CMD_READ) chk16(rspData, rows[i].e);
      else if (rows[i].c != nvsram_pkg::CMD_WRITE) chk16(rspData, 16'h0000);
      chk16({8'h00, storeCnt}, {8'h00, rows[i].s});
      chk1(autoOn, 1'b1);
    end
    // low supply: a waiting request must not be taken
    @(posedge clk_sys);
    supplyOk <= 1'b0;
    @(posedge clk_sys);
    reqValid <= 1'b1;
    repeat (6) @(negedge clk_sys);
    chk1(reqReady, 1'b0);
    chk1(memPins.ceN, 1'b1);
    @(posedge clk_sys);
    supplyOk <= 1'b1;
    req(nvsram_pkg::CMD_READ, 20'h00005, 16'h0000);
    chk16(rspData, 16'ha5a5);
    summarize();
  end

  initial begin
    #400000;
    fails++;
    summarize();
  end
endmodule
